// ---- hdl/tem_consts.svh ----
// Offsets, reset values, ranges and timing counts of the tracking error monitor
// How it works
// R1 - Evaluate tracking error every 1 ms tick
// R2 - Compare offset minus feedforward speed part
// R3 - Over limit: stop movement, flag configurable class
// R4 - Peak error held unsigned, full 32 bits
// R5 - Any write to peak register clears it
// R6 - Current deviation readable as signed 32 bits
// R7 - Current deviation is raw setpoint minus actual
// R8 - Limit writable, range 1 to 2000000, default 10000
// R9 - Amplifier overload peak over last 10 s; the code keeps values up to two 10 s windows old
// R10 - Motor overload peak over last 10 s; the code keeps values up to two 10 s windows old
// R11 - Operator sets limit near five times minimum
// R12 - Peak replaced when current magnitude is larger
`ifndef TEM_CONSTS_SVH
`define TEM_CONSTS_SVH

// Register addresses on the parameter port
`define TEM_ADDR_PEAK_ERR   16'h111E
`define TEM_ADDR_LIMIT      16'h121C
`define TEM_ADDR_AMP_PEAK   16'h1C30
`define TEM_ADDR_MOT_NOW    16'h1C32
`define TEM_ADDR_MOT_LOAD   16'h1C34
`define TEM_ADDR_MOT_PEAK   16'h1C36
`define TEM_ADDR_DEVIATION  16'h1E24

// Limit range and reset value
`define TEM_LIMIT_MIN       32'h0000_0001
`define TEM_LIMIT_DEFAULT   32'h0000_2710
`define TEM_LIMIT_MAX       32'h001E_8480

// Timing
`define TEM_CLK_PERIOD_NS   5
`define TEM_TICK_NS         1000000
`define TEM_TICK_CYCLES     (`TEM_TICK_NS / `TEM_CLK_PERIOD_NS)
`define TEM_WINDOW_MS       10000
`define TEM_TICK_MS         1
`define TEM_WINDOW_TICKS    (`TEM_WINDOW_MS / `TEM_TICK_MS)

`endif

// ---- hdl/tem_pkg.sv ----
// Types and shared arithmetic of the tracking error monitor
package tem_pkg;

	typedef logic signed [31:0] tem_pos_t;
	typedef logic        [31:0] tem_word_t;
	typedef logic signed [15:0] tem_pct_t;
	typedef logic        [2:0]  tem_class_t;

	// Magnitude of a signed position, most negative value maps to 2^31
	function automatic tem_word_t tem_abs(input tem_pos_t v);
		tem_abs = v[31] ? tem_word_t'(-v) : tem_word_t'(v);
	endfunction

	// Signed maximum of two percentages
	function automatic tem_pct_t tem_max(input tem_pct_t a, input tem_pct_t b);
		tem_max = (a > b) ? a : b;
	endfunction

endpackage

// ---- hdl/tem_peak_if.sv ----
// Carrier between the monitor core and a windowed peak detector
`timescale 1ns/1ps
interface tem_peak_if;
	logic              tick;
	tem_pkg::tem_pct_t sample;
	tem_pkg::tem_pct_t peak;

	modport core (output tick, output sample, input peak);
	modport det  (input tick, input sample, output peak);
endinterface

// ---- hdl/tem_peak_hold.sv ----
// Sliding peak of an overload percentage over a window of ticks
`timescale 1ns/1ps
`include "tem_consts.svh"
module tem_peak_hold #(
	parameter int WINDOW_TICKS = `TEM_WINDOW_TICKS
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Sample and result
	tem_peak_if.det   pk
);

	localparam int CW = $clog2(WINDOW_TICKS + 1);

	logic [CW-1:0]     win_cnt_q;
	tem_pkg::tem_pct_t cur_max_q;
	tem_pkg::tem_pct_t prev_max_q;
	tem_pkg::tem_pct_t peak_q;

	// Window position in ticks
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			win_cnt_q <= '0;
		end else if (pk.tick) begin
			if (win_cnt_q == CW'(WINDOW_TICKS - 1)) begin
				win_cnt_q <= '0;
			end else begin
				win_cnt_q <= win_cnt_q + CW'(1);
			end
		end
	end

	// Last full window and the running one; result is max of the two, so it never
	// forgets a value younger than one window, at most two windows old
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cur_max_q  <= 16'sh0000;
			prev_max_q <= 16'sh0000;
		end else if (pk.tick) begin
			if (win_cnt_q == CW'(WINDOW_TICKS - 1)) begin
				prev_max_q <= tem_pkg::tem_max(cur_max_q, pk.sample);
				cur_max_q  <= pk.sample;
			end else begin
				cur_max_q  <= tem_pkg::tem_max(cur_max_q, pk.sample);
			end
		end
	end

	// Registered result
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			peak_q <= 16'sh0000;
		end else begin
			peak_q <= tem_pkg::tem_max(cur_max_q, prev_max_q);
		end
	end

	assign pk.peak = peak_q;

endmodule

// ---- hdl/tem_top.sv ----
// Tracking error supervision with peak, deviation and overload registers
`timescale 1ns/1ps
`include "tem_consts.svh"
module tem_top #(
	parameter int TICK_CYCLES  = `TEM_TICK_CYCLES,
	parameter int WINDOW_TICKS = `TEM_WINDOW_TICKS
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	// Position loop values, same clock domain
	input  wire tem_pkg::tem_pos_t  setpoint_pos_i,
	input  wire tem_pkg::tem_pos_t  actual_pos_i,
	input  wire tem_pkg::tem_pos_t  speed_ff_offset_i,
	// Overload percentages from the load model
	input  wire tem_pkg::tem_pct_t  amp_overload_now_i,
	input  wire tem_pkg::tem_pct_t  motor_overload_now_i,
	input  wire tem_pkg::tem_pct_t  motor_load_factor_i,
	// Fault configuration and acknowledge
	input  wire tem_pkg::tem_class_t error_class_i,
	input  wire logic               fault_clear_i,
	// Parameter access port
	input  wire logic [15:0]        par_addr_i,
	input  wire logic               par_rd_i,
	input  wire logic               par_wr_i,
	input  wire tem_pkg::tem_word_t par_wdata_i,
	output tem_pkg::tem_word_t       par_rdata_o,
	output logic                    par_ack_o,
	output logic                    par_err_o,
	// Fault outputs
	output logic                    stop_move_o,
	output logic                    track_err_o,
	output tem_pkg::tem_class_t      track_err_class_o,
	output logic                    tick_o
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// Zero fill of a 16-bit register into the read word; the upper half stays
	// zero so the master sees the raw pattern and does its own sign handling
	function automatic tem_pkg::tem_word_t zext16(input tem_pkg::tem_pct_t v);
		zext16 = {16'h0000, v};
	endfunction

	// Datapath and register state
	logic [TW-1:0]        tick_cnt_q;
	logic                 tick_q;
	tem_pkg::tem_pos_t    dev_raw;
	tem_pkg::tem_pos_t    track_err;
	tem_pkg::tem_word_t   track_mag;
	tem_pkg::tem_pos_t    deviation_q;
	tem_pkg::tem_word_t   peak_err_q;
	tem_pkg::tem_word_t   limit_q;
	tem_pkg::tem_pct_t    motor_now_q;
	tem_pkg::tem_pct_t    motor_load_q;
	// Fault latch and write decode
	logic                 stop_q;
	logic                 err_q;
	tem_pkg::tem_class_t  class_q;
	logic                 wr_peak;
	logic                 wr_limit;
	logic                 limit_ok;

	// Carriers to the two peak detectors
	tem_peak_if amp_pk ();
	tem_peak_if mot_pk ();

	// Monitoring tick, one pulse per interval; the count restarts at reset
	// release, so the first evaluation lands TICK_CYCLES edges later
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1; // [R1]
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
			tick_q     <= 1'b0;
		end
	end

	// Raw deviation, and the torque relevant part with feedforward removed
	// Combinational, so the tick samples the positions of its own cycle
	// Magnitude is unsigned, so the most negative error still compares
	assign dev_raw   = setpoint_pos_i - actual_pos_i; // [R7]
	assign track_err = dev_raw - speed_ff_offset_i; // [R2]
	assign track_mag = tem_pkg::tem_abs(track_err);

	// Live deviation kept every clock so reads are never stale
	// One cycle behind the position inputs, which a master cannot resolve
	// Feedforward is not removed here, unlike the monitored error
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			deviation_q <= 32'sh0000_0000;
		end else begin
			deviation_q <= dev_raw; // [R6]
		end
	end

	// Register strobes
	// Decoded from the live request; a write wins over a read in one cycle
	assign wr_peak  = par_wr_i && (par_addr_i == `TEM_ADDR_PEAK_ERR);
	assign wr_limit = par_wr_i && (par_addr_i == `TEM_ADDR_LIMIT);
	assign limit_ok = (par_wdata_i >= `TEM_LIMIT_MIN) && (par_wdata_i <= `TEM_LIMIT_MAX);

	// Peak error; an update in the clearing cycle survives the clear
	// A tick in the write cycle restarts the peak from the current magnitude
	// Compare is unsigned on the magnitude, so a negative error counts too
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			peak_err_q <= 32'h0000_0000;
		end else if (wr_peak) begin
			peak_err_q <= tick_q ? track_mag : 32'h0000_0000; // [R5] [R12]
		end else if (tick_q && (track_mag > peak_err_q)) begin
			peak_err_q <= track_mag; // [R4] [R12]
		end
	end

	// Limit; out of range writes are refused and keep the old value
	// Only the range is enforced; the margin above normal error is the user's
	// Refused data leaves the old limit in place and raises the error flag
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			limit_q <= `TEM_LIMIT_DEFAULT; // [R8]
		end else if (wr_limit && limit_ok) begin
			limit_q <= par_wdata_i; // [R8]
		end
	end

	// Fault latch; stays until acknowledged, a new violation wins
	// Set beats clear, so an acknowledge cannot hide a fault found that tick
	// The class is kept after a clear so the last cause can still be read
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			stop_q  <= 1'b0;
			err_q   <= 1'b0;
			class_q <= 3'h0;
		end else if (tick_q && (track_mag > limit_q)) begin
			stop_q  <= 1'b1; // [R3]
			err_q   <= 1'b1; // [R3]
			class_q <= error_class_i; // [R3]
		end else if (fault_clear_i) begin
			stop_q  <= 1'b0;
			err_q   <= 1'b0;
		end
	end

	// Motor values latched so reads are glitch free
	// These pass through untouched; the load model owns their scaling
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			motor_now_q  <= 16'sh0000;
			motor_load_q <= 16'sh0000;
		end else begin
			motor_now_q  <= motor_overload_now_i;
			motor_load_q <= motor_load_factor_i;
		end
	end

	// Windowed peaks for amplifier and motor
	// Both share the monitor tick, so their windows stay aligned
	assign amp_pk.tick   = tick_q;
	assign amp_pk.sample = amp_overload_now_i;
	assign mot_pk.tick   = tick_q;
	assign mot_pk.sample = motor_overload_now_i;

	// Amplifier overload peak
	tem_peak_hold #(
		.WINDOW_TICKS (WINDOW_TICKS)
	) u_amp_peak (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.pk       (amp_pk) // [R9]
	);

	// Motor overload peak
	tem_peak_hold #(
		.WINDOW_TICKS (WINDOW_TICKS)
	) u_mot_peak (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.pk       (mot_pk) // [R10]
	);

	// Read and write answers, one cycle after the strobe
	// No wait states: every strobe is answered, refused ones by the error flag
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			par_rdata_o <= 32'h0000_0000;
			par_ack_o   <= 1'b0;
			par_err_o   <= 1'b0;
		end else begin
			// Idle defaults; ack, error and data each stand one cycle
			par_ack_o   <= par_rd_i || par_wr_i;
			par_err_o   <= 1'b0;
			par_rdata_o <= 32'h0000_0000;
			if (par_wr_i) begin
				// Only peak and limit take writes
				par_err_o <= !(wr_peak || (wr_limit && limit_ok));
			end else if (par_rd_i) begin
				// Unmapped reads answer zero data with the error flag
				unique case (par_addr_i)
					`TEM_ADDR_PEAK_ERR:  par_rdata_o <= peak_err_q; // [R4]
					`TEM_ADDR_LIMIT:     par_rdata_o <= limit_q;
					`TEM_ADDR_AMP_PEAK:  par_rdata_o <= zext16(amp_pk.peak); // [R9]
					`TEM_ADDR_MOT_NOW:   par_rdata_o <= zext16(motor_now_q);
					`TEM_ADDR_MOT_LOAD:  par_rdata_o <= zext16(motor_load_q);
					`TEM_ADDR_MOT_PEAK:  par_rdata_o <= zext16(mot_pk.peak); // [R10]
					`TEM_ADDR_DEVIATION: par_rdata_o <= deviation_q; // [R6]
					default:             par_err_o   <= 1'b1;
				endcase
			end
		end
	end

	// Fault outputs straight from flops
	// Plain wires from the state flops keep the outputs free of decode glitches
	assign stop_move_o       = stop_q;
	assign track_err_o       = err_q;
	assign track_err_class_o = class_q;
	assign tick_o            = tick_q;

endmodule

// ---- test/tem_top_asserts.sv ----
// Port checker of the tracking error monitor
`timescale 1ns/1ps
module tem_top_asserts (
	// Clock and reset
	input wire logic                clk_i,
	input wire logic                resetn_i,
	// Fault side
	input wire tem_pkg::tem_class_t error_class_i,
	input wire logic                fault_clear_i,
	input wire logic                stop_move_o,
	input wire logic                track_err_o,
	input wire tem_pkg::tem_class_t track_err_class_o,
	input wire logic                tick_o,
	// Parameter port
	input wire logic [15:0]         par_addr_i,
	input wire logic                par_rd_i,
	input wire logic                par_wr_i,
	input wire tem_pkg::tem_word_t  par_rdata_o,
	input wire logic                par_ack_o,
	input wire logic                par_err_o
);
	// One domain, so one clocking for all
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_ack_follows: assert property ((par_rd_i || par_wr_i) |=> par_ack_o)
		else $error("ack missing after strobe");
	a_ack_cause: assert property (par_ack_o |-> $past(par_rd_i || par_wr_i))
		else $error("ack without strobe");
	a_rdata_idle: assert property (!par_ack_o |-> par_rdata_o == '0)
		else $error("read data outside ack");
	a_ro_refused: assert property (par_wr_i && par_addr_i == 16'h1E24 |=> par_err_o)
		else $error("write to read-only deviation accepted");
	// Bench runs a 10-cycle tick
	a_tick_period: assert property (tick_o |=> !tick_o [*8] ##1 !tick_o ##1 tick_o)
		else $error("tick period wrong");
	a_stop_on_tick: assert property ($rose(stop_move_o) |-> $past(tick_o))
		else $error("stop raised off a tick");
	a_class_latch: assert property ($rose(track_err_o)
		|-> track_err_class_o == $past(error_class_i))
		else $error("fault class not latched");
	a_flags_agree: assert property (stop_move_o == track_err_o)
		else $error("stop and fault disagree");
	a_fault_holds: assert property (track_err_o && !fault_clear_i |=> track_err_o)
		else $error("fault dropped without clear");
	a_clear_works: assert property (fault_clear_i && !tick_o |=> !track_err_o)
		else $error("fault clear ignored");
endmodule

bind tem_top tem_top_asserts i_chk (.clk_i, .resetn_i, .error_class_i, .fault_clear_i,
	.stop_move_o, .track_err_o, .track_err_class_o, .tick_o, .par_addr_i, .par_rd_i,
	.par_wr_i, .par_rdata_o, .par_ack_o, .par_err_o);

// ---- test/tem_bus_master.sv ----
// Fieldbus master model on the parameter port
`timescale 1ns/1ps
module tem_bus_master (
	// Clock and answer
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        ack_i,
	input  wire logic        err_i,
	// Request
	output logic      [15:0] addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [31:0] wdata_o
);
	// Idle bus from time zero
	initial begin
		{addr_o, rd_o, wr_o, wdata_o} = '0;
	end

	// One-cycle strobe, address and data held until the answer is taken
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic ok);
		int n;
		@(negedge clk_i);
		{addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d};
		@(negedge clk_i);
		{wr_o, rd_o} = 2'b00;
		for (n = 0; n < 4 && ack_i !== 1'b1; n++) @(negedge clk_i);
		q = rdata_i;
		e = err_i;
		ok = (ack_i === 1'b1);
	endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench of the tracking error monitor
`timescale 1ns/1ps
module testbench;
	logic                clk_i = 0;
	logic                resetn_i = 0;
	logic                fclr = 0;
	tem_pkg::tem_pos_t   sp = 0, ac = 0, ff = 0;
	tem_pkg::tem_pct_t   amp = 0, mot = 0, lod = 0;
	tem_pkg::tem_class_t cls = 3'h5, ecls;
	logic [15:0]         addr;
	logic [31:0]         wd, rdat, q;
	logic                rd, wr, ack, err, stop, terr, tick;
	int                  mismatches = 0, compares = 0;

	// 200 MHz clock
	initial forever #2.5 clk_i = ~clk_i;

	tem_top #(.TICK_CYCLES(10), .WINDOW_TICKS(4)) i_tem_top (.clk_i(clk_i),
		.resetn_i(resetn_i), .setpoint_pos_i(sp), .actual_pos_i(ac), .speed_ff_offset_i(ff),
		.amp_overload_now_i(amp), .motor_overload_now_i(mot), .motor_load_factor_i(lod),
		.error_class_i(cls), .fault_clear_i(fclr), .par_addr_i(addr), .par_rd_i(rd),
		.par_wr_i(wr), .par_wdata_i(wd), .par_rdata_o(rdat), .par_ack_o(ack),
		.par_err_o(err), .stop_move_o(stop), .track_err_o(terr),
		.track_err_class_o(ecls), .tick_o(tick));
	tem_bus_master i_tem_bus_master (.clk_i(clk_i), .rdata_i(rdat), .ack_i(ack),
		.err_i(err), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wd));

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	// Access with ack and error check
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic xe);
		logic e, ok;
		i_tem_bus_master.xfer(w, a, d, q, e, ok);
		chk("ack", 1, ok);
		if (ok !== 1'b1)
			conclude();
		chk("err", xe, e);
	endtask
	task automatic rdc(input string s, input logic [15:0] a, input logic [31:0] x);
		acc(0, a, 0, 0);
		chk(s, x, q);
	endtask
	// Wait k ticks, bounded, then let results land
	task automatic ticks(input int k);
		int n;
		repeat (k) begin
			for (n = 0; n < 20 && tick !== 1'b1; n++) @(negedge clk_i);
			if (n == 20) begin
				mismatches++;
				conclude();
			end
			@(negedge clk_i);
		end
		repeat (3) @(negedge clk_i);
	endtask

	task automatic s_regs();
		rdc("limit", 16'h121C, 32'h0000_2710);
		rdc("peak", 16'h111E, 32'h0000_0000);
		acc(1, 16'h121C, 32'h0000_0000, 1);
		acc(1, 16'h121C, 32'h001E_8481, 1);
		acc(1, 16'h121C, 32'h0000_0820, 0);
		rdc("limit", 16'h121C, 32'h0000_0820);
		acc(1, 16'h1E24, 32'h0000_0005, 1);
		acc(1, 16'h1C36, 32'h0000_0005, 1);
		acc(0, 16'h0002, 32'h0000_0000, 1);
		sp = -5;
		ac = 10;
		ff = 7;
		rdc("dev", 16'h1E24, 32'hFFFF_FFF1);
	endtask
	task automatic s_fault();
		sp = 3000;
		ac = 0;
		ff = 920;
		ticks(1);
		chk("stop", 0, stop);
		chk("fault", 0, terr);
		rdc("peak", 16'h111E, 32'h0000_0820);
		ff = 900;
		ticks(1);
		chk("stop", 1, stop);
		chk("fault", 1, terr);
		chk("class", 5, ecls);
		rdc("peak", 16'h111E, 32'h0000_0834);
		sp = 0;
		ff = 0;
		ticks(1);
		fclr = 1;
		@(negedge clk_i);
		fclr = 0;
		chk("stop", 0, stop);
		chk("fault", 0, terr);
		acc(1, 16'h111E, 32'hA5A5_A5A5, 0);
		rdc("peak", 16'h111E, 32'h0000_0000);
	endtask
	task automatic s_load();
		amp = 50;
		mot = 80;
		lod = -3;
		ticks(1);
		rdc("amp", 16'h1C30, 32'h0000_0032);
		rdc("mnow", 16'h1C32, 32'h0000_0050);
		rdc("mload", 16'h1C34, 32'h0000_FFFD);
		rdc("mpeak", 16'h1C36, 32'h0000_0050);
		amp = 0;
		mot = 0;
		ticks(9);
		rdc("amp", 16'h1C30, 32'h0000_0000);
		rdc("mpeak", 16'h1C36, 32'h0000_0000);
	endtask

	initial begin
		repeat (20) @(negedge clk_i);
		resetn_i = 1;
		s_regs();
		s_fault();
		s_load();
		conclude();
	end
endmodule
